// ### verilog/ebtp_cfg.svh
// Constants for the eight-bit timer with prescaler: offsets, fields, reset values, timing.
// Assumes an 8-bit register port and a 200 MHz system clock.
`ifndef EBTP_CFG_SVH
`define EBTP_CFG_SVH

`define EBTP_ADDR_PRESCALER  8'hd2
`define EBTP_ADDR_COUNT      8'hd3
`define EBTP_ADDR_STATUS     8'hd4
`define EBTP_ADDR_IRQ_STATUS 8'hd5
`define EBTP_ADDR_IRQ_MASK   8'hd6

`define EBTP_RST_PRESCALER   7'h7f
`define EBTP_RST_COUNT       8'hff
`define EBTP_RST_STATUS      8'h00
`define EBTP_COUNT_ZERO      8'h00

`define EBTP_BIT_UNDERFLOW   7
`define EBTP_BIT_IRQ_ENABLE  6
`define EBTP_BIT_DIRECTION   5
`define EBTP_BIT_DATA_OUT    4
`define EBTP_BIT_RUN         3

`define EBTP_INT_DIVIDE      12
`define EBTP_CLK_PERIOD_NS   5

`endif

// ### verilog/ebtp_pkg.sv
// Types shared by the eight-bit timer design files.
// Assumes the constants header is included by users where needed.
package ebtp_pkg;
  typedef enum logic [1:0] {
    EBTP_EVENT_COUNT,
    EBTP_GATED,
    EBTP_OUTPUT
  } ebtp_mode_t;
endpackage

// ### verilog/ebtp_div12.sv
// Divide-by-twelve tick generator feeding the prescaler.
// Assumes a single clock and an enable that freezes the count.
`timescale 1ns/1ps
`default_nettype none
`include "ebtp_cfg.svh"
module ebtp_div12
  import ebtp_pkg::*;
#(
  parameter int DIVIDE = `EBTP_INT_DIVIDE
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  output logic      o_tick
);
  logic [3:0] count;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count  <= 4'h0;
      o_tick <= 1'b0;
    end else if (i_ce) begin
      if (count == 4'(DIVIDE - 1)) begin
        count  <= 4'h0;
        o_tick <= 1'b1;
      end else begin
        count  <= count + 4'h1;
        o_tick <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### verilog/ebtp_timer.sv
// Eight-bit downcounter with 7-bit prescaler, timer pin and register port.
// Assumes synchronous pin inputs and a master that never needs wait states.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
`include "ebtp_cfg.svh"
module ebtp_timer
  import ebtp_pkg::*;
#(
  parameter int PRESCALE_W = 7,
  parameter int COUNT_W    = 8
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_pin,
  output logic            o_pin,
  output logic            o_pin_oe_n,
  output logic            o_irq,
  output logic            o_wake
);
  logic [PRESCALE_W-1:0] prescaler_value;
  logic [COUNT_W-1:0]    count_value;
  logic                  underflow_flag;
  logic                  underflow_irq_enable;
  logic                  pin_direction_select;
  logic                  data_out;
  logic                  prescaler_run;
  logic [2:0]            tap_select;
  logic [1:0]            irq_status;
  logic [1:0]            irq_mask;
  logic                  pin_prev;
  logic                  div_tick;
  logic                  pre_tick;
  logic                  tap_pulse;
  logic                  underflow_evt;
  logic                  flag_rise;
  logic                  wr_count;
  logic                  wr_status;
  logic                  wr_pre;
  logic [PRESCALE_W-1:0] next_prescaler;
  ebtp_mode_t            mode;

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  ebtp_div12 u_div12 (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .o_tick  (div_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock source selection and prescaler.

  always_comb begin
    if (pin_direction_select) begin
      mode = EBTP_OUTPUT;
    end else if (data_out) begin
      mode = EBTP_GATED;
    end else begin
      mode = EBTP_EVENT_COUNT;
    end
  end

  always_comb begin
    case (mode)
      EBTP_GATED:       pre_tick = div_tick & i_pin;
      EBTP_EVENT_COUNT: pre_tick = i_pin & ~pin_prev;
      EBTP_OUTPUT:      pre_tick = div_tick;
      default:          pre_tick = 1'b0;
    endcase
  end

  assign wr_pre    = i_wr && is_addr(i_addr, `EBTP_ADDR_PRESCALER);
  assign wr_count  = i_wr && is_addr(i_addr, `EBTP_ADDR_COUNT);
  assign wr_status = i_wr && is_addr(i_addr, `EBTP_ADDR_STATUS);

  // The tap fires when the prescaler passes through a multiple of the divisor.
  assign next_prescaler = (prescaler_value == '0) ? `EBTP_RST_PRESCALER
                                                  : prescaler_value - 7'h01;
  always_comb begin
    tap_pulse = 1'b0;
    if (prescaler_run && pre_tick) begin
      if (tap_select == 3'h0) begin
        tap_pulse = 1'b1;
      end else begin
        tap_pulse = (prescaler_value & 7'((1 << tap_select) - 1)) == '0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_prev <= 1'b0;
    end else if (i_ce) begin
      pin_prev <= i_pin;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prescaler_value <= `EBTP_RST_PRESCALER;
    end else if (i_ce) begin
      if (!prescaler_run) begin
        prescaler_value <= `EBTP_RST_PRESCALER;
      end else if (wr_pre) begin
        prescaler_value <= i_wdata[6:0];
      end else if (pre_tick) begin
        prescaler_value <= next_prescaler;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter and underflow detection.

  // A counter write wins over a decrement in the same cycle, so that underflow is lost.
  assign underflow_evt = tap_pulse && !wr_count && (count_value == `EBTP_COUNT_ZERO);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_value <= `EBTP_RST_COUNT;
    end else if (i_ce) begin
      if (wr_count) begin
        count_value <= i_wdata;
      end else if (tap_pulse) begin
        count_value <= count_value - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status/control register.

  assign flag_rise = !underflow_flag && (underflow_evt
                     || (wr_count && i_wdata == `EBTP_COUNT_ZERO)
                     || (wr_status && i_wdata[`EBTP_BIT_UNDERFLOW]));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      underflow_flag <= 1'b0;
    end else if (i_ce) begin
      if (underflow_evt || (wr_count && i_wdata == `EBTP_COUNT_ZERO)) begin
        underflow_flag <= 1'b1;
      end else if (wr_status) begin
        underflow_flag <= i_wdata[`EBTP_BIT_UNDERFLOW];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      underflow_irq_enable <= 1'b0;
      pin_direction_select <= 1'b0;
      data_out             <= 1'b0;
      prescaler_run        <= 1'b0;
      tap_select           <= 3'h0;
    end else if (i_ce && wr_status) begin
      underflow_irq_enable <= i_wdata[`EBTP_BIT_IRQ_ENABLE];
      pin_direction_select <= i_wdata[`EBTP_BIT_DIRECTION];
      data_out             <= i_wdata[`EBTP_BIT_DATA_OUT];
      prescaler_run        <= i_wdata[`EBTP_BIT_RUN];
      tap_select           <= i_wdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timer pin.

  // The level is latched on each flag rise, so later data-out writes wait for the next one.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin      <= 1'b0;
      o_pin_oe_n <= 1'b1;
    end else if (i_ce) begin
      o_pin_oe_n <= ~(wr_status ? i_wdata[`EBTP_BIT_DIRECTION] : pin_direction_select);
      if (flag_rise) begin
        o_pin <= data_out;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and outputs.

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status <= 2'h0;
      irq_mask   <= 2'h0;
    end else if (i_ce) begin
      if (i_wr && is_addr(i_addr, `EBTP_ADDR_IRQ_MASK)) begin
        irq_mask <= i_wdata[1:0];
      end
      // A new event wins over a write-one clear in the same cycle.
      irq_status <= (irq_status & ~((i_wr && is_addr(i_addr, `EBTP_ADDR_IRQ_STATUS)) ? i_wdata[1:0] : 2'h0))
                    | {wr_count, underflow_evt};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq  <= 1'b0;
      o_wake <= 1'b0;
    end else if (i_ce) begin
      o_irq  <= (underflow_flag && underflow_irq_enable) || |(irq_status & irq_mask);
      o_wake <= underflow_flag && underflow_irq_enable;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      o_rdata <= 8'h00;
      if (i_rd) begin
        case (i_addr)
          `EBTP_ADDR_PRESCALER:  o_rdata <= {1'b0, prescaler_value};
          `EBTP_ADDR_COUNT:      o_rdata <= count_value;
          `EBTP_ADDR_STATUS:     o_rdata <= {underflow_flag, underflow_irq_enable, pin_direction_select,
                                             data_out, prescaler_run, tap_select};
          `EBTP_ADDR_IRQ_STATUS: o_rdata <= {6'h00, irq_status};
          `EBTP_ADDR_IRQ_MASK:   o_rdata <= {6'h00, irq_mask};
          default:               o_rdata <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_irq_follows_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && underflow_flag && underflow_irq_enable |=> o_irq)
    else $error("Interrupt missing while flag and enable set.");

  a_bit7_reads_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_rd && i_addr == `EBTP_ADDR_PRESCALER |=> !o_rdata[7])
    else $error("Prescaler bit 7 read as one.");

  a_count_reads_live: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_rd && i_addr == `EBTP_ADDR_COUNT |=> o_rdata == $past(count_value))
    else $error("Counter read does not match count.");

  a_underflow_sets: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && underflow_evt |=> underflow_flag && count_value == `EBTP_RST_COUNT)
    else $error("Underflow did not set flag and reload.");

  a_flag_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    underflow_flag && !wr_status |=> underflow_flag)
    else $error("Flag cleared without software.");

  a_pin_direction: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !wr_status |=> o_pin_oe_n == !pin_direction_select)
    else $error("Pin enable disagrees with direction bit.");

  a_pin_level: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && flag_rise |=> o_pin == $past(data_out))
    else $error("Pin did not take data-out on flag rise.");

  a_stopped_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !prescaler_run && !wr_count |=> prescaler_value == `EBTP_RST_PRESCALER && $stable(count_value))
    else $error("Stopped timer moved.");

  a_write_zero_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && wr_count && i_wdata == `EBTP_COUNT_ZERO |=> underflow_flag)
    else $error("Zero write did not set flag.");

  a_count_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && tap_pulse && !wr_count |=> count_value == $past(count_value) - 8'h01)
    else $error("Counter did not step once.");

  a_wake_out: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && underflow_flag && underflow_irq_enable |=> o_wake)
    else $error("Wake missing.");

  a_wake_off_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !underflow_irq_enable |=> !o_wake)
    else $error("Wake raised while interrupt disabled.");

  a_irq_off_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !underflow_irq_enable && irq_mask == 2'h0 |=> !o_irq)
    else $error("Interrupt raised while disabled.");

  // A frozen enable must hold every counting register, or a stalled core sees time pass.
  a_ce_freezes_state: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_ce |=> $stable(count_value) && $stable(prescaler_value) && $stable(underflow_flag))
    else $error("State moved while clock enable low.");

  // The wrap from zero lands on the reload value, so one check covers both steps.
  a_event_tick_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && prescaler_run && !pin_direction_select && !data_out && !wr_pre && i_pin && !pin_prev
    |=> prescaler_value == $past(prescaler_value) - 7'h01)
    else $error("Pin rising edge did not step prescaler.");

  a_gate_low_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && prescaler_run && !pin_direction_select && data_out && !i_pin && !wr_pre
    |=> $stable(prescaler_value))
    else $error("Gated prescaler moved with pin low.");

  a_tap_zero_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && prescaler_run && pre_tick && tap_select == 3'h0 && !wr_count
    |=> count_value == $past(count_value) - 8'h01)
    else $error("Divide-by-one tap missed a tick.");

  a_write_wins: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && wr_count |=> count_value == $past(i_wdata))
    else $error("Counter write lost to decrement.");

  a_status_write_sets: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && wr_status && i_wdata[`EBTP_BIT_UNDERFLOW] |=> underflow_flag)
    else $error("Status write of flag did not set it.");

  a_prescaler_reads: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_rd && i_addr == `EBTP_ADDR_PRESCALER |=> o_rdata[6:0] == $past(prescaler_value))
    else $error("Prescaler read does not match count.");

  a_status_reads: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_rd && i_addr == `EBTP_ADDR_STATUS
    |=> o_rdata[7] == $past(underflow_flag) && o_rdata[3] == $past(prescaler_run))
    else $error("Status read does not match fields.");
endmodule
`default_nettype wire

// ### bench/ebtp_pin_model.sv
// External source on the timer pin: counted event pulses or a steady level.
// Assumes one clock; the bench picks the pin level from the timer's pin output enable.
`timescale 1ns/1ps
`default_nettype none
module ebtp_pin_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_start,
  input  wire logic [7:0] i_count,
  input  wire logic       i_level,
  output logic            o_pin,
  output logic            o_busy
);
  logic [8:0] left;
  assign o_busy = (left != 9'h000);
  // Each pulse is one cycle high and one cycle low, so two events never merge.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      left  <= 9'h000;
      o_pin <= 1'b0;
    end else if (i_start) begin
      left  <= {i_count, 1'b0};
      o_pin <= 1'b0;
    end else if (o_busy) begin
      left  <= left - 9'h001;
      o_pin <= ~left[0];
    end else begin
      o_pin <= i_level;
    end
  end
endmodule
`default_nettype wire

// ### bench/eight_bit_timer_prescaler_tb.sv
// Self-checking bench for the eight-bit timer: registers, pin modes, flag, interrupt.
// Assumes the pin model beside it and a 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module eight_bit_timer_prescaler_tb;
  logic       clk   = 1'b0;
  logic       rst_n = 1'b0;
  logic       ce    = 1'b1;
  logic [7:0] addr  = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic       start = 1'b0;
  logic [7:0] cnt   = 8'h00;
  logic       lvl   = 1'b0;
  logic [7:0] rdata;
  logic [7:0] v;
  logic       pin_o;
  logic       oe_n;
  logic       irq;
  logic       wake;
  logic       m_pin;
  logic       busy;
  wire        pin_w = oe_n ? m_pin : pin_o;
  int         failures   = 0;
  int         n_compared = 0;

  always #2.5 clk = ~clk;

  ebtp_timer dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pin(pin_w), .o_pin(pin_o), .o_pin_oe_n(oe_n),
    .o_irq(irq), .o_wake(wake));
  ebtp_pin_model far_u (.i_clk(clk), .i_rst_n(rst_n), .i_start(start), .i_count(cnt),
    .i_level(lvl), .o_pin(m_pin), .o_busy(busy));
////////////////////////////////////////
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
    cmp(v, exp);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic pls(input logic [7:0] n);
    int i;
    @(posedge clk);
    cnt   <= n;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    i = 0;
    while (busy === 1'b1 && i < 600) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (i >= 600) begin
      failures++;
      close_out();
    end
    repeat (3) @(posedge clk);
  endtask
////////////////////////////////////////
  task automatic t_reset();
    chk(8'hd2, 8'h7f);
    chk(8'hd3, 8'hff);
    chk(8'hd4, 8'h00);
    chk(8'hc0, 8'h00);
    cmp({7'h00, oe_n}, 8'h01);
    $display("reset test done");
  endtask
  task automatic t_event();
    wr8(8'hd4, 8'h08);
    pls(8'h03);
    chk(8'hd3, 8'hfc);
    chk(8'hd2, 8'h7c);
    wr8(8'hd3, 8'h01);
    pls(8'h02);
    chk(8'hd3, 8'hff);
    chk(8'hd4, 8'h88);
    cmp({7'h00, irq}, 8'h00);
    $display("event test done");
  endtask
  task automatic t_irq();
    chk(8'hd5, 8'h03);
    wr8(8'hd6, 8'h01);
    settle();
    cmp({7'h00, irq}, 8'h01);
    wr8(8'hd5, 8'h03);
    settle();
    cmp({7'h00, irq}, 8'h00);
    wr8(8'hd6, 8'h00);
    wr8(8'hd4, 8'hc8);
    settle();
    cmp({7'h00, irq}, 8'h01);
    cmp({7'h00, wake}, 8'h01);
    wr8(8'hd4, 8'h48);
    settle();
    cmp({7'h00, irq}, 8'h00);
    wr8(8'hd3, 8'h00);
    chk(8'hd4, 8'hc8);
    wr8(8'hd4, 8'h00);
    chk(8'hd2, 8'h7f);
    pls(8'h03);
    chk(8'hd3, 8'h00);
    $display("flag test done");
  endtask
  task automatic t_taps();
    int n;
    logic [7:0] k;
    for (n = 0; n < 8; n++) begin
      k = 8'h01 << n;
      wr8(8'hd4, 8'h00);
      wr8(8'hd3, 8'hff);
      wr8(8'hd4, 8'h08 | 8'(n));
      pls(k - 8'h01);
      chk(8'hd3, 8'hff);
      pls(8'h01);
      chk(8'hd3, 8'hfe);
      chk(8'hd2, (8'h7f - k) & 8'h7f);
    end
    $display("tap test done");
  endtask
  task automatic t_out();
    // Slowest tap so no natural underflow lands on the clearing write.
    wr8(8'hd4, 8'h00);
    wr8(8'hd4, 8'h3f);
    settle();
    cmp({7'h00, oe_n}, 8'h00);
    wr8(8'hd3, 8'h00);
    settle();
    cmp({7'h00, pin_o}, 8'h01);
    wr8(8'hd4, 8'h2f);
    wr8(8'hd3, 8'h00);
    settle();
    cmp({7'h00, pin_o}, 8'h00);
    wr8(8'hd4, 8'h00);
    settle();
    cmp({7'h00, oe_n}, 8'h01);
    $display("output test done");
  endtask
  task automatic t_gate();
    wr8(8'hd4, 8'h18);
    repeat (60) @(posedge clk);
    chk(8'hd2, 8'h7f);
    @(posedge clk);
    lvl <= 1'b1;
    repeat (120) @(posedge clk);
    lvl <= 1'b0;
    // The pin is seen high on 120 edges in a row, which always holds ten divided ticks.
    chk(8'hd2, 8'h75);
    cmp({7'h00, v >= 8'h74 && v <= 8'h76}, 8'h01);
    $display("gated test done");
  endtask
  task automatic t_freeze();
    wr8(8'hd4, 8'h00);
    wr8(8'hd3, 8'h10);
    wr8(8'hd4, 8'h08);
    @(posedge clk);
    ce <= 1'b0;
    pls(8'h02);
    ce <= 1'b1;
    chk(8'hd3, 8'h10);
    pls(8'h01);
    chk(8'hd3, 8'h0f);
    $display("freeze test done");
  endtask
////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_event();
    t_irq();
    t_taps();
    t_out();
    t_gate();
    t_freeze();
    close_out();
  end
endmodule
`default_nettype wire
